// file: logic/bbsu_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module bbsu_decoder (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  order_byte_valid,
    input  wire logic            [7:0] order_byte,
    output logic                       order_byte_ready,
    output logic                       order_busy,
    input  wire bbsu_pkg::bbsu_xfer_t  xfer,
    input  wire logic                  xfer_progress,
    input  wire logic           [31:0] xfer_physical_address,
    output logic                       xfer_execute,
    output logic                       xfer_bottom_up,
    output logic                       xfer_reverse_table,
    output logic                [31:0] xfer_start_physical,
    output logic                       xfer_abort,
    output logic                       writeback_valid,
    output logic                [31:0] writeback_logical,
    output logic                 [7:0] writeback_band,
    output bbsu_pkg::bbsu_setup_t      setup,
    output bbsu_pkg::bbsu_codes_t      codes
);
    import bbsu_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BBSU_IDLE,
        BBSU_SETUP,
        BBSU_CODE
    } bbsu_phase_t;

    typedef struct packed {
        bbsu_phase_t phase;
        logic [3:0]  index;
        logic [7:0]  opcode;
        bbsu_setup_t shadow;
        bbsu_setup_t setup;
        bbsu_codes_t codes;

        logic        active;
        logic [7:0]  band;
        logic        scanline;
        logic        banded;
        logic        wb_valid;
        logic [31:0] wb_logical;
        logic [7:0]  wb_band;
        logic        abort;
        logic        execute;
        logic        bottom_up;
        logic        reverse;
        logic [31:0] start_phys;
    } bbsu_state_t;

    bbsu_state_t state;
    bbsu_state_t next_state;

    logic [31:0] mapped_start;
    logic [31:0] mapped_back;
    logic        fault_now;

    // ------------------------------------------------------------
    // byte and transfer decode
    // ------------------------------------------------------------
    logic        in_setup;
    logic        take_band;
    logic        take_direction;
    logic        take_warp;
    logic        take_offset;
    logic        take_end;
    logic        setup_done;
    logic        xfer_start;
    logic        band_fault;

    assign in_setup       = order_byte_valid && (state.phase == BBSU_SETUP);
    assign take_band      = in_setup && (state.index == BYTE_BAND);
    assign take_direction = in_setup && (state.index == BYTE_DIRECTION);
    assign take_warp      = in_setup && (state.index >= BYTE_WARP_HI)
                                     && (state.index < BYTE_OFFSET_HI);
    assign take_offset    = in_setup && (state.index >= BYTE_OFFSET_HI)
                                     && (state.index < BYTE_END_HI);
    assign take_end       = in_setup && (state.index >= BYTE_END_HI);
    assign setup_done     = in_setup && (state.index == SETUP_LAST_BYTE);
    // only a banded order has a band buffer to run off the end of
    assign xfer_start     = xfer.valid && !state.active;
    assign band_fault     = state.active && state.banded && xfer_progress && fault_now;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_code_order(input logic [7:0] op);
        is_code_order = (op == OP_SET_DEST_ONLY) || (op == OP_SET_TONE_DEST) ||
                        (op == OP_SET_SRC_DEST)  || (op == OP_SET_THREE_OPERAND);
    endfunction : is_code_order

    function automatic logic is_banded(input bbsu_xfer_t x);
        is_banded = (x.target == BBSU_TGT_BANDED);
    endfunction : is_banded

    // big-endian field loading: each new byte enters at the low end
    function automatic logic [31:0] shift_in32(input logic [31:0] cur, input logic [7:0] b);
        shift_in32 = {cur[23:0], b};
    endfunction : shift_in32

    function automatic logic [15:0] shift_in16(input logic [15:0] cur, input logic [7:0] b);
        shift_in16 = {cur[7:0], b};
    endfunction : shift_in16

    // scanline orders move on to the next band in render order
    function automatic logic [7:0] step_band(input logic [7:0] band, input logic down);
        step_band = down ? band - 8'h01 : band + 8'h01;
    endfunction : step_band

    bbsu_translate u_translate (
        .logical_in   (xfer.destination_pointer),
        .physical_in  (xfer_physical_address),
        .offset       (state.setup.phys_minus_logical_offset),
        .end_address  (state.setup.strip_end_address),
        .bottom_up    (state.setup.bottom_up_flag),
        .physical_out (mapped_start),
        .logical_out  (mapped_back),
        .fault        (fault_now)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state          = state;
        next_state.wb_valid = 1'b0;
        next_state.abort    = 1'b0;
        next_state.execute  = 1'b0;

        // order byte stream; setup is staged so a half-loaded order never leaks
        if (order_byte_valid) begin
            unique case (state.phase)
                BBSU_IDLE: begin
                    next_state.opcode = order_byte;
                    next_state.index  = 4'h1;
                    if (order_byte == OP_SET_STRIP_MAP) begin
                        next_state.phase  = BBSU_SETUP;
                        next_state.shadow = state.setup;
                    end else if (is_code_order(order_byte)) begin
                        next_state.phase = BBSU_CODE;
                    end else begin
                        // not an order of this block: the byte is dropped
                        next_state.phase = BBSU_IDLE;
                    end
                end
                BBSU_SETUP: begin
                    next_state.index = state.index + 4'h1;
                    // byte 1 is reserved and dropped
                    if (take_band) begin
                        next_state.shadow.band = order_byte;
                    end
                    if (take_direction) begin
                        next_state.shadow.bottom_up_flag = order_byte[BOTTOM_UP_BIT];
                    end
                    if (take_warp) begin
                        next_state.shadow.strip_map_warp =
                            shift_in16(state.shadow.strip_map_warp, order_byte);
                    end
                    if (take_offset) begin
                        next_state.shadow.phys_minus_logical_offset =
                            shift_in32(state.shadow.phys_minus_logical_offset, order_byte);
                    end
                    if (take_end) begin
                        next_state.shadow.strip_end_address =
                            shift_in32(state.shadow.strip_end_address, order_byte);
                    end
                    if (setup_done) begin
                        next_state.phase = BBSU_IDLE;
                        next_state.setup = next_state.shadow;
                    end
                end
                BBSU_CODE: begin
                    next_state.phase = BBSU_IDLE;
                    unique case (state.opcode)
                        OP_SET_DEST_ONLY: begin
                            next_state.codes.dest_only_logic_code = order_byte;
                        end
                        OP_SET_TONE_DEST: begin
                            next_state.codes.tone_dest_logic_code = order_byte;
                        end
                        OP_SET_SRC_DEST: begin
                            next_state.codes.src_dest_logic_code = order_byte;
                        end
                        default: begin
                            next_state.codes.three_operand_logic_code = order_byte;
                        end
                    endcase
                end
                default: next_state.phase = BBSU_IDLE;
            endcase
        end

        // transfer start: banded orders need a band match and take the strip setup
        if (xfer_start) begin
            next_state.band     = xfer.band;
            next_state.scanline = xfer.is_scanline;
            next_state.banded   = is_banded(xfer);
            if (is_banded(xfer)) begin
                next_state.execute = (xfer.band == state.setup.band);
                next_state.bottom_up = state.setup.bottom_up_flag;
                next_state.reverse = xfer.is_scanline && state.setup.bottom_up_flag;
                next_state.start_phys = mapped_start;
            end else begin
                // frames and unbanded maps skip the band test and the mapping
                next_state.execute    = 1'b1;
                next_state.bottom_up  = 1'b0;
                next_state.reverse    = 1'b0;
                next_state.start_phys = xfer.destination_pointer;
            end
            next_state.active = next_state.execute;
        end

        // band fault ends the transfer and hands back the order's new values
        if (band_fault) begin
            next_state.active     = 1'b0;
            next_state.abort      = 1'b1;
            next_state.wb_valid   = 1'b1;
            next_state.wb_logical = mapped_back;
            next_state.wb_band    = state.band;
            if (state.scanline) begin
                next_state.wb_band = step_band(state.band, state.setup.bottom_up_flag);
            end
        end else if (state.active && !xfer.valid) begin
            next_state.active = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state                                  <= '0;
            state.phase                            <= BBSU_IDLE;
            state.setup.band                       <= RESET_BAND;
            state.setup.strip_map_warp             <= RESET_WARP;
            state.setup.phys_minus_logical_offset  <= RESET_OFFSET;
            state.setup.strip_end_address          <= RESET_END;
            state.codes.dest_only_logic_code       <= RESET_LOGIC_CODE;
            state.codes.tone_dest_logic_code       <= RESET_LOGIC_CODE;
            state.codes.src_dest_logic_code        <= RESET_LOGIC_CODE;
            state.codes.three_operand_logic_code   <= RESET_LOGIC_CODE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // software keeps the warp a multiple of 16 for engine output
    // offset and end address are taken as given
    assign order_byte_ready    = 1'b1;
    assign order_busy          = (state.phase != BBSU_IDLE);

    // ------------------------------------------------------------
    // transfer side outputs
    // ------------------------------------------------------------
    assign xfer_execute        = state.execute;
    assign xfer_bottom_up      = state.bottom_up;
    assign xfer_reverse_table  = state.reverse;
    assign xfer_start_physical = state.start_phys;
    assign xfer_abort          = state.abort;
    assign writeback_valid     = state.wb_valid;
    assign writeback_logical   = state.wb_logical;
    assign writeback_band      = state.wb_band;
    assign setup               = state.setup;
    assign codes               = state.codes;
endmodule : bbsu_decoder
`default_nettype wire

// file: logic/bbsu_pkg.sv
package bbsu_pkg;

    // ------------------------------------------------------------
    // order codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_STRIP_MAP      = 8'h08;
    localparam logic [7:0] OP_SET_DEST_ONLY      = 8'h0c;
    localparam logic [7:0] OP_SET_TONE_DEST      = 8'h0d;
    localparam logic [7:0] OP_SET_SRC_DEST       = 8'h0e;
    localparam logic [7:0] OP_SET_THREE_OPERAND  = 8'h0f;
    localparam logic [7:0] RESERVED_BYTE         = 8'h00;

    // ------------------------------------------------------------
    // setup order layout, bytes after the opcode
    // ------------------------------------------------------------
    localparam logic [3:0] SETUP_LAST_BYTE       = 4'hd;
    localparam logic [3:0] BYTE_RESERVED         = 4'h1;
    localparam logic [3:0] BYTE_BAND             = 4'h2;
    localparam logic [3:0] BYTE_DIRECTION        = 4'h3;
    localparam logic [3:0] BYTE_WARP_HI          = 4'h4;
    localparam logic [3:0] BYTE_OFFSET_HI        = 4'h6;
    localparam logic [3:0] BYTE_END_HI           = 4'ha;
    localparam int         BOTTOM_UP_BIT         = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RESET_BAND           = 8'h00;
    localparam logic [15:0] RESET_WARP           = 16'h0000;
    localparam logic [31:0] RESET_OFFSET         = 32'h00000000;
    localparam logic [31:0] RESET_END            = 32'hffffffff;
    localparam logic [7:0]  RESET_LOGIC_CODE     = 8'h00;

    typedef enum logic [1:0] {
        BBSU_TGT_FRAME,
        BBSU_TGT_UNBANDED,
        BBSU_TGT_BANDED
    } bbsu_target_t;

    typedef struct packed {
        logic [7:0]  band;
        logic        bottom_up_flag;
        logic [15:0] strip_map_warp;
        logic [31:0] phys_minus_logical_offset;
        logic [31:0] strip_end_address;
    } bbsu_setup_t;

    typedef struct packed {
        logic [7:0] dest_only_logic_code;
        logic [7:0] tone_dest_logic_code;
        logic [7:0] src_dest_logic_code;
        logic [7:0] three_operand_logic_code;
    } bbsu_codes_t;

    // transfer order being checked by the translation side
    typedef struct packed {
        logic         valid;
        bbsu_target_t target;
        logic         is_scanline;
        logic [7:0]   band;
        logic [31:0]  destination_pointer;
    } bbsu_xfer_t;

endpackage : bbsu_pkg

// file: logic/bbsu_translate.sv
`timescale 1ns/1ns
`default_nettype none
module bbsu_translate (
    input  wire logic [31:0] logical_in,
    input  wire logic [31:0] physical_in,
    input  wire logic [31:0] offset,
    input  wire logic [31:0] end_address,
    input  wire logic        bottom_up,
    output logic      [31:0] physical_out,
    output logic      [31:0] logical_out,
    output logic             fault
);
    // ------------------------------------------------------------
    // address mapping, modulo 2^32 so the sign needs no extension
    // ------------------------------------------------------------
    assign physical_out = logical_in + offset;
    assign logical_out  = physical_in - offset;
    // unsigned compare: physical addresses never wrap inside a band
    assign fault = bottom_up ? (physical_in <= end_address)
                             : (physical_in >= end_address);
endmodule : bbsu_translate
`default_nettype wire

// file: tb/bbsu_decoder_properties.sv
`timescale 1ns/1ns
`default_nettype none
module bbsu_decoder_properties (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  order_byte_valid,
    input wire logic            [7:0] order_byte,
    input wire logic                  order_byte_ready,
    input wire logic                  order_busy,
    input wire bbsu_pkg::bbsu_xfer_t  xfer,
    input wire logic                  xfer_progress,
    input wire logic           [31:0] xfer_physical_address,
    input wire logic                  xfer_execute,
    input wire logic           [31:0] xfer_start_physical,
    input wire logic                  xfer_abort,
    input wire logic                  writeback_valid,
    input wire logic           [31:0] writeback_logical,
    input wire bbsu_pkg::bbsu_setup_t setup,
    input wire bbsu_pkg::bbsu_codes_t codes
);
    import bbsu_pkg::*;
    // ------------------------------------------------------------
    // order and transfer properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence code_order(logic [7:0] op);
        order_byte_valid && !order_busy && order_byte == op ##1 order_byte_valid;
    endsequence
    a_ready_always: assert property (order_byte_ready)
        else $error("ready dropped");
    a_dest_code: assert property (code_order(OP_SET_DEST_ONLY) |=>
        codes.dest_only_logic_code == $past(order_byte)) else $error("dest code");
    a_three_code: assert property (code_order(OP_SET_THREE_OPERAND) |=>
        codes.three_operand_logic_code == $past(order_byte)) else $error("three code");
    a_codes_hold: assert property (!order_byte_valid |=> $stable(codes))
        else $error("codes moved");
    a_setup_hold: assert property (!order_byte_valid |=> $stable(setup))
        else $error("setup moved");
    a_band_gate: assert property ($rose(xfer.valid) && xfer.target == BBSU_TGT_BANDED
        |=> xfer_execute == ($past(xfer.band) == $past(setup.band))) else $error("band gate");
    a_start_phys: assert property (xfer_execute && $past(xfer.target) == BBSU_TGT_BANDED
        |-> xfer_start_physical == $past(xfer.destination_pointer)
        + setup.phys_minus_logical_offset) else $error("start address");
    a_frame_no_abort: assert property (xfer_execute && $past(xfer.target) != BBSU_TGT_BANDED
        |=> !xfer_abort) else $error("frame fault");
    a_abort_pair: assert property (xfer_abort |-> writeback_valid ##1 !xfer_abort)
        else $error("abort pulse");
    a_wb_logical: assert property (writeback_valid |-> writeback_logical
        == $past(xfer_physical_address) - setup.phys_minus_logical_offset)
        else $error("writeback address");
    a_fault_cause: assert property (xfer_abort |-> $past(xfer_progress)
        && (setup.bottom_up_flag ? $past(xfer_physical_address) <= setup.strip_end_address
        : $past(xfer_physical_address) >= setup.strip_end_address)) else $error("fault");
    c_abort: cover property (xfer_abort);
    c_src_code: cover property (code_order(OP_SET_SRC_DEST));
    c_bottom_up: cover property (xfer_execute && setup.bottom_up_flag);
endmodule : bbsu_decoder_properties
`default_nettype wire

// file: tb/bbsu_list_model.sv
`timescale 1ns/1ns
`default_nettype none
module bbsu_list_model (
    input  wire logic clk,
    output logic      order_byte_valid,
    output logic [7:0] order_byte,
    output logic      list_empty
);
    // ------------------------------------------------------------
    // display list byte feed
    // ------------------------------------------------------------
    logic [7:0] list_q[$];
    task automatic push(input logic [7:0] b);
        list_q.push_back(b);
        // marks the feed busy at once so a waiting drain never sees stale empty
        list_empty = 1'b0;
    endtask : push
    initial begin
        order_byte_valid = 1'b0;
        order_byte = 8'h00;
        list_empty = 1'b1;
    end
    // idle bytes toggle so a stale value never passes for data
    always @(posedge clk) begin
        #1;
        order_byte_valid = list_q.size() > 0;
        order_byte = order_byte_valid ? list_q.pop_front() : ~order_byte;
        list_empty = list_q.size() == 0;
    end
endmodule : bbsu_list_model
`default_nettype wire

// file: tb/bbsu_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bbsu_decoder_bench;
    import bbsu_pkg::*;
    logic        clk;
    logic        reset;
    logic        order_byte_valid;
    logic  [7:0] order_byte;
    logic        order_byte_ready;
    logic        order_busy;
    bbsu_xfer_t  xfer;
    logic        xfer_progress;
    logic [31:0] xfer_physical_address;
    logic        xfer_execute;
    logic        xfer_bottom_up;
    logic        xfer_reverse_table;
    logic [31:0] xfer_start_physical;
    logic        xfer_abort;
    logic        writeback_valid;
    logic [31:0] writeback_logical;
    logic  [7:0] writeback_band;
    logic        list_empty;
    bbsu_setup_t setup;
    bbsu_codes_t codes;
    int          num_errors;
    int          checks_done;
    bbsu_decoder u_bbsu_decoder (.*);
    bbsu_list_model u_bbsu_list_model (.*);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic put(input logic [7:0] b);
        u_bbsu_list_model.push(b);
    endtask : put
    // feed is seen empty on the edge that takes the last byte, then two more edges pass
    task automatic drain();
        for (int n = 0; n < 40 && list_empty !== 1'b1; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask : drain
    task automatic send_setup(input logic [7:0] rsv, input logic [7:0] bd,
                              input logic [7:0] dir, input logic [31:0] off);
        put(OP_SET_STRIP_MAP);
        put(rsv);
        put(bd);
        put(dir);
        put(8'h01);
        put(8'h00);
        for (int i = 3; i >= 0; i--) put(off[8*i +: 8]);
        for (int i = 3; i >= 0; i--) put(8'(32'h00010000 >> (8*i)));
        drain();
    endtask : send_setup
    task automatic run_xfer(input bbsu_target_t tg, input logic sl, input logic [7:0] bd,
                            input logic [31:0] ptr, input logic [31:0] pa,
                            input logic [3:0] fl, input logic [31:0] st,
                            input logic [7:0] wb);
        xfer = '{1'b1, tg, sl, bd, ptr};
        @(posedge clk);
        #1;
        chk({29'h0, xfer_execute, xfer_bottom_up, xfer_reverse_table}, {29'h0, fl[3:1]});
        if (xfer_execute === 1'b1) begin
            chk(xfer_start_physical, st);
            // every running order sees one progress beat; only banded ones may fault
            xfer_physical_address = pa;
            xfer_progress = 1'b1;
            @(posedge clk);
            #1;
            xfer_progress = 1'b0;
            chk({30'h0, xfer_abort, writeback_valid}, {30'h0, fl[0], fl[0]});
            if (fl[0]) chk({writeback_logical[23:0], writeback_band}, {24'h011000, wb});
        end
        xfer.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : run_xfer
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        num_errors = 0;
        checks_done = 0;
        reset = 1'b1;
        xfer = '0;
        xfer_progress = 1'b0;
        xfer_physical_address = 32'h00000000;
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        chk(setup.strip_end_address, RESET_END);
        chk({codes[30:0], order_byte_ready}, 32'h00000001);
        chk({30'h0, order_busy, writeback_valid}, 32'h0);
        $display("reset test done");
        // a byte that opens no order of this block is dropped on its own
        put(8'h33);
        for (int i = 0; i < 4; i++) begin
            put(OP_SET_DEST_ONLY + 8'(i));
            if (i == 1) begin
                drain();
                chk({31'h0, order_busy}, 32'h1);
            end
            put(8'ha0 + 8'(i));
        end
        drain();
        chk(codes, 32'ha0a1a2a3);
        $display("code test done");
        // offset: buffer at 0 minus top pixel at 1000
        send_setup(8'h5a, 8'h03, 8'hfe, 32'hfffff000);
        chk({setup.band, 7'h0, setup.bottom_up_flag, setup.strip_map_warp}, 32'h03000100);
        chk(setup.phys_minus_logical_offset, 32'hfffff000);
        chk(setup.strip_end_address, 32'h00010000);
        chk(codes, 32'ha0a1a2a3);
        run_xfer(BBSU_TGT_BANDED, 1'b1, 8'h03, 32'h00001100, 32'h00010000, 4'b1001,
                 32'h00000100, 8'h04);
        run_xfer(BBSU_TGT_BANDED, 1'b0, 8'h03, 32'h00001200, 32'h0000ffff, 4'b1000,
                 32'h00000200, 8'h00);
        run_xfer(BBSU_TGT_BANDED, 1'b0, 8'h02, 32'h00001200, 32'h0, 4'b0000,
                 32'h0, 8'h00);
        $display("top down test done");
        send_setup(8'h00, 8'h05, 8'h01, 32'hfffff000);
        chk({31'h0, setup.bottom_up_flag}, 32'h1);
        // address 0 lies past the end for bottom up, yet frames must not fault
        run_xfer(BBSU_TGT_FRAME, 1'b0, 8'h00, 32'h00002000, 32'h0, 4'b1000,
                 32'h00002000, 8'h00);
        run_xfer(BBSU_TGT_UNBANDED, 1'b1, 8'h00, 32'h00003000, 32'h0, 4'b1000,
                 32'h00003000, 8'h00);
        run_xfer(BBSU_TGT_BANDED, 1'b1, 8'h05, 32'h00010f00, 32'h00010001, 4'b1110,
                 32'h0000ff00, 8'h00);
        run_xfer(BBSU_TGT_BANDED, 1'b1, 8'h05, 32'h00010f00, 32'h00010000, 4'b1111,
                 32'h0000ff00, 8'h04);
        run_xfer(BBSU_TGT_BANDED, 1'b0, 8'h05, 32'h00010e00, 32'h00010000, 4'b1101,
                 32'h0000fe00, 8'h05);
        $display("bottom up test done");
        stop_test();
    end
endmodule : bbsu_decoder_bench
bind bbsu_decoder bbsu_decoder_properties u_bbsu_decoder_properties (.*);
`default_nettype wire
